/* hw/wdcc_top.sv */
// top: 8-bit watchdog / interval counter with control bits
//
// What this block does
// - run bit set: count selected prescaler ticks
// - run cleared: stop and zero, unless sub
// - sub selected: stop keeps count; write zero
// - select zero: count main-clock prescaler ticks
// - select one: count sub-clock prescaler ticks
// - overflow raises reset or NMI request
// - action bit zero: overflow requests NMI
`timescale 1ns/1ps
module wdcc_top
   import wdcc_pkg::*;
#(
   parameter int MAIN_DIV = WDCC_MAIN_DIV,
   parameter int SUB_DIV = WDCC_SUB_DIV
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_sub_clk_en,
   input wire logic i_count_run_bit,
   input wire logic i_sub_clock_prescaler_select,
   input wire logic i_overflow_action_reset,
   input wire logic i_count_write,
   input wire logic [7:0] i_count_wdata,
   output logic [7:0] o_watchdog_count_value,
   output logic o_reset_req,
   output logic o_nmi_req
);
   // ------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------
   // async assert, sync release: every flop reset by rstn leaves reset together
   logic [1:0] rst_sync_q;
   logic rstn;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rstn = rst_sync_q[1];

   // sub clock enable comes from another domain's pin
   logic [1:0] sub_sync_q;
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         sub_sync_q <= 2'h0;
      end else begin
         sub_sync_q <= {sub_sync_q[0], i_sub_clk_en};
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cnt;
      logic rst_req;
      logic nmi_req;
   } wdcc_st_t;
   wdcc_st_t s_q, s_d;

   wdcc_tick_if tk ();
   // select read live: a switch takes effect at the next divider end
   assign tk.sel_sub = i_sub_clock_prescaler_select;

   wdcc_prescaler #(.MAIN_DIV(MAIN_DIV), .SUB_DIV(SUB_DIV)) u_ps (
      .i_clk(i_clk),
      .i_rstn(rstn),
      .i_sub_en(sub_sync_q[1]),
      .tk(tk)
   );

   logic ovf;
   // a stopped counter parked at FF must never raise a request
   assign ovf = i_count_run_bit && tk.tick && (s_q.cnt == WDCC_CNT_MAX);

   // ------------------------------------------------------------
   // counter and overflow action
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rst_req = 1'b0;
      s_d.nmi_req = 1'b0;
      if (i_count_write) begin
         // software write wins over a tick in the same cycle
         s_d.cnt = i_count_wdata;
      end else if (i_count_run_bit) begin
         if (tk.tick) begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end else if (!i_sub_clock_prescaler_select) begin
         s_d.cnt = WDCC_CNT_RST;
      end
      if (ovf && !i_count_write) begin
         if (i_overflow_action_reset == WDCC_ACT_RESET) begin
            s_d.rst_req = 1'b1;
         end else begin
            s_d.nmi_req = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_watchdog_count_value = s_q.cnt;
   assign o_reset_req = s_q.rst_req;
   assign o_nmi_req = s_q.nmi_req;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_RUN_INC: assert property (@(posedge i_clk) disable iff (!rstn)
      (i_count_run_bit && tk.tick && !i_count_write)
      |=> o_watchdog_count_value == 8'($past(s_q.cnt) + 8'h01))
      else $error("count did not advance on tick");
   AST_STOP_CLR: assert property (@(posedge i_clk) disable iff (!rstn)
      (!i_count_run_bit && !i_sub_clock_prescaler_select && !i_count_write)
      |=> o_watchdog_count_value == 8'h00)
      else $error("stopped main counter not cleared");
   AST_SUB_HOLD: assert property (@(posedge i_clk) disable iff (!rstn)
      (!i_count_run_bit && i_sub_clock_prescaler_select && !i_count_write)
      |=> $stable(o_watchdog_count_value))
      else $error("stopped sub counter changed");
   AST_WRITE: assert property (@(posedge i_clk) disable iff (!rstn)
      i_count_write |=> o_watchdog_count_value == $past(i_count_wdata))
      else $error("count write lost");
   AST_MAIN_SEL: assert property (@(posedge i_clk) disable iff (!rstn)
      (tk.tick && !$past(i_sub_clock_prescaler_select))
      |-> $past(u_ps.s_q.main_cnt) == 16'(MAIN_DIV - 1))
      else $error("main tick off divider");
   AST_SUB_SEL: assert property (@(posedge i_clk) disable iff (!rstn)
      (tk.tick && $past(i_sub_clock_prescaler_select))
      |-> $past(u_ps.s_q.sub_cnt) == 16'(SUB_DIV - 1))
      else $error("sub tick off divider");
   AST_OVF_ONE: assert property (@(posedge i_clk) disable iff (!rstn)
      !(o_reset_req && o_nmi_req))
      else $error("both overflow requests raised");
   AST_NMI: assert property (@(posedge i_clk) disable iff (!rstn)
      (ovf && !i_count_write && !i_overflow_action_reset)
      |=> o_nmi_req && !o_reset_req && o_watchdog_count_value == 8'h00)
      else $error("overflow did not request NMI");
   AST_RST: assert property (@(posedge i_clk) disable iff (!rstn)
      (ovf && !i_count_write && i_overflow_action_reset)
      |=> o_reset_req && !o_nmi_req && o_watchdog_count_value == 8'h00)
      else $error("overflow did not request reset");

   // ------------------------------------------------------------
   // checks: counting and stopping
   // ------------------------------------------------------------
   // no tick and no write: the count must not creep
   AST_RUN_WAIT: assert property (@(posedge i_clk) disable iff (!rstn)
      (i_count_run_bit && !tk.tick && !i_count_write)
      |=> $stable(o_watchdog_count_value))
      else $error("count moved without a tick");
   AST_STOP_QUIET: assert property (@(posedge i_clk) disable iff (!rstn)
      !i_count_run_bit |=> !o_reset_req && !o_nmi_req)
      else $error("stopped counter raised a request");

   // ------------------------------------------------------------
   // checks: prescaler divide and select
   // ------------------------------------------------------------
   AST_MAIN_RANGE: assert property (@(posedge i_clk) disable iff (!rstn)
      u_ps.s_q.main_cnt < 16'(MAIN_DIV))
      else $error("main divider out of range");
   AST_MAIN_STEP: assert property (@(posedge i_clk) disable iff (!rstn)
      (u_ps.s_q.main_cnt != 16'(MAIN_DIV - 1))
      |=> u_ps.s_q.main_cnt == 16'($past(u_ps.s_q.main_cnt) + 16'h0001))
      else $error("main divider skipped a step");
   AST_MAIN_WRAP: assert property (@(posedge i_clk) disable iff (!rstn)
      (u_ps.s_q.main_cnt == 16'(MAIN_DIV - 1))
      |=> u_ps.s_q.main_cnt == 16'h0000)
      else $error("main divider did not wrap");
   AST_MAIN_GATE: assert property (@(posedge i_clk) disable iff (!rstn)
      (!i_sub_clock_prescaler_select
       && u_ps.s_q.main_cnt != 16'(MAIN_DIV - 1)) |=> !tk.tick)
      else $error("main tick before divider end");
   AST_SUB_RANGE: assert property (@(posedge i_clk) disable iff (!rstn)
      u_ps.s_q.sub_cnt < 16'(SUB_DIV))
      else $error("sub divider out of range");
   // the sub divider must freeze while the sub clock is parked
   AST_SUB_FROZEN: assert property (@(posedge i_clk) disable iff (!rstn)
      !sub_sync_q[1] |=> $stable(u_ps.s_q.sub_cnt))
      else $error("sub divider ran without enable");
   AST_SUB_STEP: assert property (@(posedge i_clk) disable iff (!rstn)
      (sub_sync_q[1] && u_ps.s_q.sub_cnt != 16'(SUB_DIV - 1))
      |=> u_ps.s_q.sub_cnt == 16'($past(u_ps.s_q.sub_cnt) + 16'h0001))
      else $error("sub divider skipped a step");
   AST_SUB_WRAP: assert property (@(posedge i_clk) disable iff (!rstn)
      (sub_sync_q[1] && u_ps.s_q.sub_cnt == 16'(SUB_DIV - 1))
      |=> u_ps.s_q.sub_cnt == 16'h0000)
      else $error("sub divider did not wrap");
   AST_SUB_GATE: assert property (@(posedge i_clk) disable iff (!rstn)
      (i_sub_clock_prescaler_select
       && u_ps.s_q.sub_cnt != 16'(SUB_DIV - 1)) |=> !tk.tick)
      else $error("sub tick before divider end");
   AST_SUB_IDLE: assert property (@(posedge i_clk) disable iff (!rstn)
      (i_sub_clock_prescaler_select && !sub_sync_q[1]) |=> !tk.tick)
      else $error("sub tick while sub clock idle");

   // ------------------------------------------------------------
   // checks: overflow requests
   // ------------------------------------------------------------
   // a request with no overflow behind it would reset the chip at random
   AST_REQ_PULSE: assert property (@(posedge i_clk) disable iff (!rstn)
      (o_reset_req || o_nmi_req) |=> !o_reset_req && !o_nmi_req)
      else $error("overflow request held too long");
   AST_NMI_CAUSE: assert property (@(posedge i_clk) disable iff (!rstn)
      o_nmi_req |-> $past(ovf) && !$past(i_count_write)
         && !$past(i_overflow_action_reset))
      else $error("NMI request without overflow");
   AST_RST_CAUSE: assert property (@(posedge i_clk) disable iff (!rstn)
      o_reset_req |-> $past(ovf) && !$past(i_count_write)
         && $past(i_overflow_action_reset))
      else $error("reset request without overflow");
endmodule

/* hw/wdcc_pkg.sv */
// package: constants and types for the watchdog counter control block
package wdcc_pkg;
   localparam int WDCC_CNT_W = 8;
   localparam logic [7:0] WDCC_CNT_RST = 8'h00;
   localparam logic [7:0] WDCC_CNT_MAX = 8'hFF;
   localparam int WDCC_MAIN_DIV = 4;
   localparam int WDCC_SUB_DIV = 16;
   localparam logic WDCC_CTRL_RST = 1'b0;
   localparam logic WDCC_ACT_NMI = 1'b0;
   localparam logic WDCC_ACT_RESET = 1'b1;
endpackage

/* hw/wdcc_tick_if.sv */
// interface: prescaler tick handshake between divider and counter
`timescale 1ns/1ps
interface wdcc_tick_if;
   logic sel_sub;
   logic tick;
   modport src (input sel_sub, output tick);
   modport dst (output sel_sub, input tick);
endinterface

/* hw/wdcc_prescaler.sv */
// prescaler: main-clock and sub-clock derived tick sources
`timescale 1ns/1ps
module wdcc_prescaler
   import wdcc_pkg::*;
#(
   parameter int MAIN_DIV = WDCC_MAIN_DIV,
   parameter int SUB_DIV = WDCC_SUB_DIV
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_sub_en,
   wdcc_tick_if.src tk
);
   typedef struct packed {
      logic [15:0] main_cnt;
      logic [15:0] sub_cnt;
      logic tick;
   } wdcc_ps_t;
   wdcc_ps_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.main_cnt == 16'(MAIN_DIV - 1)) begin
         s_d.main_cnt = 16'h0000;
         if (!tk.sel_sub) begin
            s_d.tick = 1'b1;
         end
      end else begin
         s_d.main_cnt = s_q.main_cnt + 16'h0001;
      end
      if (i_sub_en) begin
         if (s_q.sub_cnt == 16'(SUB_DIV - 1)) begin
            s_d.sub_cnt = 16'h0000;
            if (tk.sel_sub) begin
               s_d.tick = 1'b1;
            end
         end else begin
            s_d.sub_cnt = s_q.sub_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.tick = s_q.tick;
endmodule

/* dv/tb_wdcc_top.sv */
// testbench: directed checks of the watchdog counter control block
`timescale 1ns/1ps
module tb_wdcc_top;
   import wdcc_pkg::*;
   logic clk = 1'b1;
   logic resetn = 1'b1;
   logic sub_en = 1'b0;
   logic run = 1'b0;
   logic sel = 1'b0;
   logic act = 1'b0;
   logic wr = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] cnt;
   logic rst_req;
   logic nmi;
   int n_mismatch = 0;
   int n_tests = 0;

   wdcc_top u_wdcc_top (.i_clk(clk), .i_resetn(resetn),
      .i_sub_clk_en(sub_en), .i_count_run_bit(run),
      .i_sub_clock_prescaler_select(sel),
      .i_overflow_action_reset(act), .i_count_write(wr),
      .i_count_wdata(wd), .o_watchdog_count_value(cnt),
      .o_reset_req(rst_req), .o_nmi_req(nmi));

   initial begin
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic results();
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr_cnt(input logic [7:0] v);
      wr = 1'b1;
      wd = v;
      cyc(1);
      wr = 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // phase of the prescaler is unknown, so sync on the first step
   task automatic period(input int div);
      logic [7:0] v;
      int i;
      v = cnt;
      for (i = 0; i < 64 && cnt === v; i++) cyc(1);
      if (i == 64) begin
         n_mismatch++;
         results();
      end
      v = cnt;
      cyc(div - 1);
      chk(cnt, v);
      cyc(1);
      chk(cnt, v + 8'h01);
      $display("period %0d done", div);
   endtask
   task automatic ovf(input logic a);
      int i;
      act = a;
      run = 1'b1;
      wr_cnt(8'hFF);
      for (i = 0; i < 16 && !(nmi === 1'b1 || rst_req === 1'b1); i++)
         cyc(1);
      if (i == 16) begin
         n_mismatch++;
         results();
      end
      chk({6'h00, rst_req, nmi}, a ? 8'h02 : 8'h01);
      chk(cnt, 8'h00);
      cyc(1);
      chk({6'h00, rst_req, nmi}, 8'h00);
      $display("overflow action %0d done", a);
   endtask
   task automatic stop_main();
      run = 1'b0;
      cyc(1);
      chk(cnt, 8'h00);
      $display("stop main done");
   endtask
   task automatic sub_hold();
      logic [7:0] v;
      run = 1'b0;
      cyc(1);
      v = cnt;
      cyc(20);
      chk(cnt, v);
      wr_cnt(8'h00);
      chk(cnt, 8'h00);
      $display("sub hold done");
   endtask
   task automatic mid_reset();
      run = 1'b1;
      wr_cnt(8'h5A);
      chk(cnt, 8'h5A);
      resetn = 1'b0;
      cyc(1);
      chk(cnt, WDCC_CNT_RST);
      chk({6'h00, rst_req, nmi}, 8'h00);
      resetn = 1'b1;
      cyc(3);
      chk(cnt, WDCC_CNT_RST);
      period(WDCC_MAIN_DIV);
      $display("mid-run reset done");
   endtask

   initial begin
      // reset falls after time zero so the async reset sees an edge
      cyc(1);
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      cyc(3);
      chk(cnt, WDCC_CNT_RST);
      chk({6'h00, rst_req, nmi}, 8'h00);
      run = 1'b1;
      period(WDCC_MAIN_DIV);
      stop_main();
      sel = 1'b1;
      sub_en = 1'b1;
      run = 1'b1;
      period(WDCC_SUB_DIV);
      sub_hold();
      sel = 1'b0;
      ovf(WDCC_ACT_NMI);
      ovf(WDCC_ACT_RESET);
      mid_reset();
      results();
   end
endmodule
